/* File: src/pesl_chan.sv */
// Purpose: Constants for the proximity event sender, and one delayed send channel
// Assumes: Single clock, synchronous active-high reset
// Notes: One channel instance per outgoing object
package pesl_pkg;
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned TICK_NS = 10000000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  localparam int unsigned MAX_OBJ = 8;
  localparam int unsigned DLY_W = 24;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_VAL = 4'h4;
  localparam logic [3:0] OFS_DLY = 4'h8;
  localparam int unsigned CB_PROX = 0;
  localparam int unsigned CB_SEND = 1;
  localparam int unsigned CB_LOCK = 2;
  localparam int unsigned CB_INV = 3;
  localparam int unsigned CB_REC = 4;
  localparam int unsigned CB_ALK = 5;
  localparam int unsigned CB_AUL = 7;
  localparam int unsigned CB_NUM = 9;
  localparam logic [12:0] CTRL_RST = 13'h0200;
  localparam logic [10:0] CFG_RST = 11'h030;
  localparam logic [15:0] UBYTE_MAX = 16'h00ff;
  localparam logic [15:0] PCT_MAX = 16'h0064;
  localparam logic [15:0] SBYTE_MAX = 16'h007f;
  localparam logic [15:0] SBYTE_MIN = 16'hff80;
  typedef enum logic [2:0] {
    PESL_D1B = 3'b000, PESL_D2B = 3'b001, PESL_DU8 = 3'b010, PESL_DPCT = 3'b011,
    PESL_DS8 = 3'b100, PESL_DU16 = 3'b101, PESL_DS16 = 3'b110, PESL_DF16 = 3'b111
  } pesl_dim_t;
  typedef enum logic [1:0] {
    PESL_ANONE = 2'b00, PESL_ADET = 2'b01, PESL_AND = 2'b10
  } pesl_lact_t;
endpackage : pesl_pkg

module pesl_chan #(
  parameter int unsigned DLY_W = pesl_pkg::DLY_W
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic cancel_i,
  input wire logic [2:0] act_i,
  input wire logic [2:0] dim_i,
  input wire logic [15:0] val1_i,
  input wire logic [15:0] val2_i,
  input wire logic [DLY_W-1:0] dly_i,
  input wire logic grant_i,
  output logic busy_o,
  output logic req_o,
  output logic [15:0] data_o
);
  logic armed_q, armed_d, pend_q, pend_d, alt_q, alt_d;
  logic [2:0] act_q;
  logic [DLY_W-1:0] cnt_q, cnt_d;
  logic [15:0] data_q, data_d, pick;
  logic fire;
  logic alt_act;

  assign fire = armed_q && cnt_q == '0;
  // Only alternating actions advance the swap state
  assign alt_act = (dim_i == pesl_pkg::PESL_D2B) ? (act_q >= 3'h4) : (act_q == 3'h3);
  assign pick = (act_q == 3'h1) ? val1_i : (act_q == 3'h2) ? val2_i : (alt_q ? val2_i : val1_i);

  always_comb begin
    data_d = data_q;
    unique case (pesl_pkg::pesl_dim_t'(dim_i))
      pesl_pkg::PESL_D1B: data_d = (act_q == 3'h1) ? 16'h0001 : (act_q == 3'h2) ? 16'h0000 :
                                   {15'h0000, ~data_q[0]};
      pesl_pkg::PESL_D2B: begin
        case (act_q)
          3'h1: data_d = 16'h0000;
          3'h2: data_d = 16'h0002;
          3'h3: data_d = 16'h0003;
          3'h4: data_d = alt_q ? 16'h0000 : 16'h0002;
          3'h5: data_d = alt_q ? 16'h0000 : 16'h0003;
          default: data_d = alt_q ? 16'h0003 : 16'h0002;
        endcase
      end
      // Values clamped to the range of the chosen type
      pesl_pkg::PESL_DU8: data_d = (pick > pesl_pkg::UBYTE_MAX) ? pesl_pkg::UBYTE_MAX : pick;
      pesl_pkg::PESL_DPCT: data_d = (pick > pesl_pkg::PCT_MAX) ? pesl_pkg::PCT_MAX : pick;
      pesl_pkg::PESL_DS8: data_d = ($signed(pick) > $signed(pesl_pkg::SBYTE_MAX)) ?
                                   pesl_pkg::SBYTE_MAX : ($signed(pick) < $signed(pesl_pkg::SBYTE_MIN)) ?
                                   pesl_pkg::SBYTE_MIN : pick;
      default: data_d = pick;
    endcase
  end

  always_comb begin
    armed_d = armed_q;
    pend_d = pend_q && !grant_i;
    cnt_d = cnt_q;
    alt_d = alt_q;
    if (fire) begin
      armed_d = 1'b0;
      pend_d = 1'b1;
      alt_d = alt_act ? ~alt_q : alt_q;
    end else if (armed_q && tick_i) begin
      cnt_d = cnt_q - 1'b1;
    end
    if (cancel_i) begin
      armed_d = 1'b0;
      pend_d = 1'b0;
    end
    if (start_i && act_i != 3'h0) begin
      armed_d = 1'b1;
      cnt_d = dly_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      armed_q <= 1'b0;
      pend_q <= 1'b0;
      alt_q <= 1'b0;
      cnt_q <= '0;
      act_q <= 3'h0;
      data_q <= 16'h0000;
    end else begin
      armed_q <= armed_d;
      pend_q <= pend_d;
      alt_q <= alt_d;
      cnt_q <= cnt_d;
      // An event with no action must not retarget a running wait
      if (start_i && act_i != 3'h0) act_q <= act_i;
      if (fire) data_q <= data_d;
    end
  end

  assign req_o = pend_q;
  assign data_o = data_q;
  assign busy_o = armed_q || pend_q;

  a_zero_delay_fire: assert property (@(posedge mclk_i) disable iff (srst_i)
    start_i && act_i != 3'h0 && dly_i == '0 && !cancel_i ##1 !cancel_i |=> pend_q)
    else $error("Zero delay did not fire in two cycles");
  a_wait_holds: assert property (@(posedge mclk_i) disable iff (srst_i)
    armed_q && cnt_q != '0 |=> !pend_q || $past(pend_q))
    else $error("Send left before its delay ran out");
endmodule : pesl_chan

/* File: src/pesl_top.sv */
// Purpose: Proximity event sender with lock, up to eight delayed send objects
// Assumes: 10 MHz mclk_i; bus stack logic on the same clock; presence is a pin
// Notes: One transmission offered per cycle, lowest object first
// What this block does
// - Sending and locking work only when the proximity sensor and value sending are enabled.
// - Up to eight outgoing objects all react to the same proximity event.
// - For byte-wide objects a first value is held and kept within the range of its type.
// - A second value is held per object, also within its type range up to 16-bit types.
// - With locking enabled, a one-bit lock command written from the bus is accepted.
// - The lock command locks either on its received level or on the inverted level.
// - When so configured the block enters locked on bus voltage return, otherwise unlocked.
// - Locking and unlocking each run a chosen action: none, presence or no-presence reaction.
// - Each object waits its own configured delay between event and sending.
//
// Chosen here: the register addresses and the strobed register port.
module pesl_top #(
  parameter int unsigned NUM_OBJ = pesl_pkg::MAX_OBJ,
  parameter int unsigned TICK_CYC = pesl_pkg::TICK_CYC
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic presence_i,
  input wire logic lock_wr_i,
  input wire logic lock_val_i,
  input wire logic bus_recover_i,
  output logic lock_o,
  output logic tx_stb_o,
  output logic [2:0] tx_obj_o,
  output logic [15:0] tx_data_o
);
  localparam int unsigned DW = pesl_pkg::DLY_W;

  if (NUM_OBJ < 1 || NUM_OBJ > pesl_pkg::MAX_OBJ) begin : g_bad_num
    $error("NUM_OBJ out of range");
  end
  if (TICK_CYC < 1) begin : g_bad_tick
    $error("TICK_CYC must be at least one");
  end

  logic [12:0] ctrl_q;
  logic [10:0] cfg_q [NUM_OBJ];
  logic [31:0] val_q [NUM_OBJ];
  logic [DW-1:0] dly_q [NUM_OBJ];
  logic [31:0] rdata_q, rdata_d;
  logic pres_s1_q, pres_s2_q, pres_q;
  logic lock_q, lock_d;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic tx_stb_q;
  logic [2:0] tx_obj_q;
  logic [15:0] tx_data_q;

  // Control fields
  wire prox_en = ctrl_q[pesl_pkg::CB_PROX];
  wire send_en = ctrl_q[pesl_pkg::CB_SEND];
  wire lock_en = ctrl_q[pesl_pkg::CB_LOCK];
  wire lock_inv = ctrl_q[pesl_pkg::CB_INV];
  wire lock_rec = ctrl_q[pesl_pkg::CB_REC];
  wire [1:0] at_lock = ctrl_q[pesl_pkg::CB_ALK +: 2];
  wire [1:0] at_unlock = ctrl_q[pesl_pkg::CB_AUL +: 2];
  wire [3:0] num_obj = ctrl_q[pesl_pkg::CB_NUM +: 4];
  wire active = prox_en && send_en;

  // Address decode
  wire [3:0] obj_sel = addr_i[7:4];
  wire [3:0] obj_ofs = addr_i[3:0];
  wire obj_hit = obj_sel != 4'h0 && {28'h0, obj_sel} <= NUM_OBJ && addr_i[1:0] == 2'b00;
  wire [2:0] obj_idx = 3'(obj_sel - 4'h1);
  wire ctrl_wr = wr_i && addr_i == pesl_pkg::ADR_CTRL;

  // Lock state
  wire lock_hit = lock_wr_i && active && lock_en;
  wire lock_cmd = lock_val_i ^ lock_inv;
  always_comb begin
    lock_d = lock_q;
    if (!active || !lock_en) begin
      lock_d = 1'b0;
    end else if (bus_recover_i) begin
      lock_d = lock_rec;
    end else if (lock_hit) begin
      lock_d = lock_cmd;
    end
  end
  wire lock_on = lock_d && !lock_q;
  wire lock_off = !lock_d && lock_q;

  // Event sources
  wire pres_rise = pres_s2_q && !pres_q;
  wire pres_fall = !pres_s2_q && pres_q;
  wire free = !lock_q && !lock_d;
  wire ev_det = active && ((pres_rise && free) ||
                (lock_on && at_lock == pesl_pkg::PESL_ADET) ||
                (lock_off && at_unlock == pesl_pkg::PESL_ADET));
  wire ev_nd = active && ((pres_fall && free) ||
               (lock_on && at_lock == pesl_pkg::PESL_AND) ||
               (lock_off && at_unlock == pesl_pkg::PESL_AND));

  logic [NUM_OBJ-1:0] req, grant, busy;
  logic [15:0] chan_data [NUM_OBJ];

  for (genvar g = 0; g < NUM_OBJ; g++) begin : g_obj
    wire used = g < num_obj;
    wire [2:0] act = ev_det ? cfg_q[g][6:4] : cfg_q[g][10:8];
    pesl_chan #(.DLY_W(DW)) u_chan (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .tick_i(tick),
      .start_i(used && (ev_det || ev_nd)),
      .cancel_i(lock_on || !active),
      .act_i(act),
      .dim_i(cfg_q[g][2:0]),
      .val1_i(val_q[g][15:0]),
      .val2_i(val_q[g][31:16]),
      .dly_i(dly_q[g]),
      .grant_i(grant[g]),
      .busy_o(busy[g]),
      .req_o(req[g]),
      .data_o(chan_data[g])
    );
  end

  // Lowest pending object wins
  logic [2:0] win_idx;
  always_comb begin
    grant = '0;
    win_idx = 3'h0;
    for (int i = NUM_OBJ - 1; i >= 0; i--) begin
      if (req[i]) begin
        grant = '0;
        grant[i] = 1'b1;
        win_idx = 3'(i);
      end
    end
  end

  // Read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (addr_i == pesl_pkg::ADR_CTRL) begin
      rdata_d = {19'h0, ctrl_q};
    end else if (addr_i == pesl_pkg::ADR_STAT) begin
      rdata_d = {16'h0, 8'(busy), 6'h0, pres_s2_q, lock_q};
    end else if (obj_hit && obj_ofs == pesl_pkg::OFS_CFG) begin
      rdata_d = {21'h0, cfg_q[obj_idx]};
    end else if (obj_hit && obj_ofs == pesl_pkg::OFS_VAL) begin
      rdata_d = val_q[obj_idx];
    end else if (obj_hit && obj_ofs == pesl_pkg::OFS_DLY) begin
      rdata_d = {{(32-DW){1'b0}}, dly_q[obj_idx]};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl_q <= pesl_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= wdata_i[12:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < NUM_OBJ; i++) begin
      if (srst_i) begin
        cfg_q[i] <= pesl_pkg::CFG_RST;
        val_q[i] <= 32'h0000_0000;
        dly_q[i] <= '0;
      end else if (wr_i && obj_hit && obj_idx == 3'(i)) begin
        if (obj_ofs == pesl_pkg::OFS_CFG) cfg_q[i] <= wdata_i[10:0];
        if (obj_ofs == pesl_pkg::OFS_VAL) val_q[i] <= wdata_i;
        if (obj_ofs == pesl_pkg::OFS_DLY) dly_q[i] <= wdata_i[DW-1:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pres_s1_q <= 1'b0;
      pres_s2_q <= 1'b0;
      pres_q <= 1'b0;
      lock_q <= 1'b0;
      tick_cnt_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
    end else begin
      pres_s1_q <= presence_i;
      pres_s2_q <= pres_s1_q;
      pres_q <= pres_s2_q;
      lock_q <= lock_d;
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      rdata_q <= rd_i ? rdata_d : 32'h0000_0000;
    end
  end
  assign tick = tick_cnt_q == TICK_CYC - 1;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tx_stb_q <= 1'b0;
      tx_obj_q <= 3'h0;
      tx_data_q <= 16'h0000;
    end else begin
      tx_stb_q <= |req;
      if (|req) begin
        tx_obj_q <= win_idx;
        tx_data_q <= chan_data[win_idx];
      end
    end
  end

  assign rdata_o = rdata_q;
  assign lock_o = lock_q;
  assign tx_stb_o = tx_stb_q;
  assign tx_obj_o = tx_obj_q;
  assign tx_data_o = tx_data_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  a_idle_no_lock: assert property (!active |=> !lock_q)
    else $error("Lock held while sender disabled");
  a_idle_no_send: assert property (!active [*3] |=> !tx_stb_o)
    else $error("Transmission while sender disabled");
  a_obj_in_range: assert property (tx_stb_o |-> {28'h0, tx_obj_o} < num_obj)
    else $error("Unused object transmitted");
  a_lock_cmd_taken: assert property (lock_hit && !bus_recover_i |=> lock_q == $past(lock_cmd))
    else $error("Lock command not applied");
  a_lock_polarity: assert property (lock_hit && !bus_recover_i && lock_inv |=>
    lock_q != $past(lock_val_i))
    else $error("Inverted lock polarity wrong");
  a_recover_state: assert property (bus_recover_i && active && lock_en |=>
    lock_q == $past(lock_rec))
    else $error("Lock state after bus return wrong");
  a_lock_action: assert property (lock_on && at_lock == pesl_pkg::PESL_ADET |-> ev_det)
    else $error("Locking action not started");
  a_unlock_action: assert property (lock_off && at_unlock == pesl_pkg::PESL_AND |-> ev_nd)
    else $error("Unlocking action not started");
  a_locked_quiet: assert property (lock_q && lock_d && at_lock == pesl_pkg::PESL_ANONE &&
    at_unlock == pesl_pkg::PESL_ANONE |-> !ev_det && !ev_nd)
    else $error("Proximity event passed while locked");
  c_send: cover property (tx_stb_o);
  c_lock_on: cover property (lock_on);
  c_unlock: cover property (lock_off ##[1:20] tx_stb_o);
  c_recover: cover property (bus_recover_i && lock_d);
endmodule : pesl_top

/* File: tb/pesl_bus_node.sv */
// Purpose: Far bus side: lock writer, voltage return, frame sink
// Assumes: Same clock as the sender
// Notes: Frames are logged with the cycle they appeared in
module pesl_bus_node (
  input wire logic mclk_i,
  input wire logic tx_stb_i,
  input wire logic [2:0] tx_obj_i,
  input wire logic [15:0] tx_data_i,
  output logic lock_wr_o,
  output logic lock_val_o,
  output logic recover_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0;
  logic [2:0] obj_q[$];
  logic [15:0] dat_q[$];
  int at_q[$];
  initial begin
    lock_wr_o = 1'b0;
    lock_val_o = 1'b0;
    recover_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (tx_stb_i === 1'b1) begin
      obj_q.push_back(tx_obj_i);
      dat_q.push_back(tx_data_i);
      at_q.push_back(cyc);
    end
  end
  // Stale lock bit flipped after the write
  task automatic send_lock(input logic v);
    @(posedge mclk_i);
    lock_wr_o <= 1'b1;
    lock_val_o <= v;
    @(posedge mclk_i);
    lock_wr_o <= 1'b0;
    lock_val_o <= ~v;
  endtask : send_lock
  task automatic recover();
    @(posedge mclk_i);
    recover_o <= 1'b1;
    @(posedge mclk_i);
    recover_o <= 1'b0;
  endtask : recover
endmodule : pesl_bus_node

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the proximity event sender with lock
// Assumes: Tick shortened to four clocks
// Notes: Random values from a fixed seed
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TCK = 4;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic presence_i = 1'b0;
  logic [31:0] rdata_o;
  logic lock_wr_i, lock_val_i, bus_recover_i, lock_o, tx_stb_o;
  logic [2:0] tx_obj_o;
  logic [15:0] tx_data_o;
  logic [15:0] v;
  logic [2:0] d;
  logic b;
  logic [2:0] eo[$];
  logic [15:0] ed[$];
  logic [15:0] dmask = 16'hffff;
  logic [2:0] dims[6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h4, 3'h3};
  int fail_count = 0;
  int tests_run = 0;
  int seed = 50;

  pesl_top #(.TICK_CYC(TCK)) i_dut (.mclk_i(mclk_i), .srst_i(srst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .presence_i(presence_i), .lock_wr_i(lock_wr_i), .lock_val_i(lock_val_i),
    .bus_recover_i(bus_recover_i), .lock_o(lock_o), .tx_stb_o(tx_stb_o),
    .tx_obj_o(tx_obj_o), .tx_data_o(tx_data_o));
  pesl_bus_node i_node (.mclk_i(mclk_i), .tx_stb_i(tx_stb_o), .tx_obj_i(tx_obj_o),
    .tx_data_i(tx_data_o), .lock_wr_o(lock_wr_i), .lock_val_o(lock_val_i),
    .recover_o(bus_recover_i));

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  function automatic logic [15:0] clamp(input logic [2:0] dm, input logic [15:0] x);
    case (dm)
      3'h2: return (x > 16'h00ff) ? 16'h00ff : x;
      3'h3: return (x > 16'h0064) ? 16'h0064 : x;
      3'h4: return ($signed(x) > 127) ? 16'h007f : ($signed(x) < -128) ? 16'hff80 : x;
      default: return x;
    endcase
  endfunction : clamp

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    tests_run++;
    if (got !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] x);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= x;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", e, rdata_o);
  endtask : rd_chk
  task automatic lk(input logic e);
    repeat (2) @(posedge mclk_i);
    #1;
    chk("lock_o", {31'h0, e}, {31'h0, lock_o});
  endtask : lk
  task automatic pres(input logic p);
    @(posedge mclk_i);
    presence_i <= p;
  endtask : pres
  task automatic det_exp();
    eo = '{3'h0, 3'h1};
    ed = '{16'h00ff, 16'h8000};
  endtask : det_exp
  task automatic frames(input int n, input bit gap);
    int g;
    repeat (n) @(posedge mclk_i);
    chk("frame_count", ed.size(), i_node.dat_q.size());
    foreach (ed[i]) begin
      if (i < i_node.dat_q.size()) begin
        chk("tx_obj", eo[i], i_node.obj_q[i]);
        chk("tx_data", ed[i] & dmask, i_node.dat_q[i] & dmask);
      end
    end
    if (gap && i_node.at_q.size() == 2) begin
      g = i_node.at_q[1] - i_node.at_q[0];
      chk("delay_gap_ok", 1, (g >= 7 && g <= 14));
    end
    eo.delete();
    ed.delete();
    i_node.obj_q.delete();
    i_node.dat_q.delete();
    i_node.at_q.delete();
  endtask : frames
  task automatic close_out();
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  initial begin
    #(100 * 8000);
    fail_count++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd_chk(8'h00, 32'h0000_0200);
    rd_chk(8'h10, 32'h0000_0030);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'hfc, 32'h0);
    wr_reg(8'h10, 32'h0000_0212);
    wr_reg(8'h14, 32'h0010_012c);
    wr_reg(8'h20, 32'h0000_0126);
    wr_reg(8'h24, 32'h8000_fff0);
    wr_reg(8'h28, 32'h0000_0003);
    wr_reg(8'h00, 32'h0000_0527);
    rd_chk(8'h28, 32'h3);
    det_exp();
    pres(1'b1);
    frames(60, 1'b1);
    rd_chk(8'h04, 32'h2);
    det_exp();
    i_node.send_lock(1'b1);
    lk(1'b1);
    frames(60, 1'b0);
    pres(1'b0);
    frames(60, 1'b0);
    eo = '{3'h0, 3'h1};
    ed = '{16'h0010, 16'hfff0};
    i_node.send_lock(1'b0);
    lk(1'b0);
    frames(60, 1'b0);
    wr_reg(8'h00, 32'h0000_040f);
    b = 1'($random(seed));
    i_node.send_lock(b);
    lk(~b);
    i_node.send_lock(~b);
    lk(b);
    wr_reg(8'h00, 32'h0000_0417);
    i_node.recover();
    lk(1'b1);
    wr_reg(8'h00, 32'h0000_0407);
    i_node.recover();
    lk(1'b0);
    wr_reg(8'h00, 32'h0000_0405);
    pres(1'b1);
    i_node.send_lock(1'b1);
    lk(1'b0);
    frames(40, 1'b0);
    wr_reg(8'h00, 32'h0000_0207);
    for (int i = 0; i < 6; i++) begin
      d = dims[i];
      v = (i == 2) ? 16'hff7f : 16'($random(seed));
      wr_reg(8'h10, {29'h2, d});
      wr_reg(8'h14, {16'h0, v});
      pres(1'b0);
      repeat (10) @(posedge mclk_i);
      eo = '{3'h0};
      ed = '{clamp(d, v)};
      dmask = (d < 3'h5) ? 16'h00ff : 16'hffff;
      pres(1'b1);
      frames(30, 1'b0);
    end
    // Two-bit object alternating enable off and enable on
    wr_reg(8'h10, 32'h0000_0661);
    eo = '{3'h0, 3'h0};
    ed = '{16'h0002, 16'h0003};
    pres(1'b0);
    repeat (10) @(posedge mclk_i);
    pres(1'b1);
    frames(30, 1'b0);
    // One-bit object: on, then toggle
    wr_reg(8'h10, 32'h0000_0130);
    eo = '{3'h0, 3'h0};
    ed = '{16'h0001, 16'h0000};
    pres(1'b0);
    repeat (10) @(posedge mclk_i);
    pres(1'b1);
    frames(30, 1'b0);
    close_out();
  end
endmodule : tb
